// ---- hw/epm_pkg.sv ----
package epm_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 18;
    localparam int DATA_W        = 16;
    localparam int ID_W          = 8;
    localparam int TMR_W         = 16;
    localparam int TRY_W         = 4;

    // Programming pulse on chip select, microseconds
    localparam int PULSE_NOM_US  = 100;
    localparam int PULSE_MIN_US  = 95;
    localparam int PULSE_MAX_US  = 105;
    localparam int PULSE_NOM_CYC = PULSE_NOM_US * 1000 / CLK_PERIOD_NS;

    // Address and data setup before a pulse, also used for supply settling
    localparam int SETUP_US  = 2;
    localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Slowest access time and output disable time
    localparam int ACCESS_NS   = 150;
    localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISABLE_NS  = 100;
    localparam int DISABLE_CYC = (DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Two-flop input synchroniser plus one cycle of margin
    localparam int SYNC_STAGES = 2;
    localparam int SAMPLE_CYC  = ACCESS_CYC + SYNC_STAGES + 1;

    localparam int MAX_TRIES = 10;
    localparam int ID_BIT    = 0;

    localparam logic [DATA_W-1:0] ID_MASK   = 16'h00ff;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;

    typedef enum logic [1:0] {
        EPM_OP_READ,
        EPM_OP_SIG,
        EPM_OP_PROG
    } epm_op_t;

    typedef struct packed {
        epm_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } epm_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              ok;
        logic [TRY_W-1:0]  tries;
    } epm_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address_inputs;
        logic              chip_sel_n;
        logic              out_drv_n;
        logic              vpp_high;
        logic              id_select_hv_pin;
        logic [DATA_W-1:0] data_pins_out;
        logic              data_pins_oe;
    } epm_pins_t;

endpackage

// ---- hw/epm_host.sv ----
`timescale 1ns/1ps
module epm_host #(
    parameter int PULSE_CYCLES = epm_pkg::PULSE_NOM_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         cmd_valid,
    output logic                              cmd_ready,
    input  wire epm_pkg::epm_cmd_t            cmd,
    output logic                              rsp_valid,
    output epm_pkg::epm_rsp_t                 rsp,
    output epm_pkg::epm_pins_t                pins,
    input  wire logic [epm_pkg::DATA_W-1:0]   data_pins_in
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_READ,
        ST_SETUP,
        ST_PULSE,
        ST_RELEASE,
        ST_VERIFY,
        ST_TURN,
        ST_REVERT,
        ST_FINAL,
        ST_DONE
    } epm_state_t;

    localparam logic [epm_pkg::TMR_W-1:0] T_PULSE   = epm_pkg::TMR_W'(PULSE_CYCLES - 1);
    localparam logic [epm_pkg::TMR_W-1:0] T_SETUP   = epm_pkg::TMR_W'(epm_pkg::SETUP_CYC - 1);
    localparam logic [epm_pkg::TMR_W-1:0] T_DISABLE = epm_pkg::TMR_W'(epm_pkg::DISABLE_CYC - 1);
    localparam logic [epm_pkg::TMR_W-1:0] T_SAMPLE  = epm_pkg::TMR_W'(epm_pkg::SAMPLE_CYC - 1);
    localparam logic [epm_pkg::TMR_W-1:0] T_ZERO    = '0;
    localparam logic [epm_pkg::TRY_W-1:0] TRY_MAX   = epm_pkg::TRY_W'(epm_pkg::MAX_TRIES);
    localparam logic [epm_pkg::TRY_W-1:0] TRY_ONE   = epm_pkg::TRY_W'(1);

    epm_state_t                      state_reg,  state_next;
    logic [epm_pkg::TMR_W-1:0]       timer_reg,  timer_next;
    logic [epm_pkg::TRY_W-1:0]       tries_reg,  tries_next;
    logic                            ok_reg,     ok_next;
    logic                            sig_reg,    sig_next;
    logic [epm_pkg::DATA_W-1:0]      want_reg,   want_next;
    logic [epm_pkg::DATA_W-1:0]      rdata_reg,  rdata_next;
    epm_pkg::epm_pins_t              pins_reg,   pins_next;
    logic [epm_pkg::DATA_W-1:0]      sync1_reg;
    logic [epm_pkg::DATA_W-1:0]      sync2_reg;
    logic                            timer_done;
    logic [epm_pkg::DATA_W-1:0]      unfixable;

    localparam epm_pkg::epm_pins_t PINS_IDLE = '{address_inputs:   epm_pkg::ADDR_ZERO,
                         chip_sel_n:       1'b1,
                         out_drv_n:        1'b1,
                         vpp_high:         1'b0,
                         id_select_hv_pin: 1'b0,
                         data_pins_out:    epm_pkg::DATA_ZERO,
                         data_pins_oe:     1'b0};

    assign timer_done = (timer_reg == T_ZERO);
    // Bits that read zero but must be one cannot be repaired
    assign unfixable  = want_reg & ~sync2_reg;

    assign cmd_ready = (state_reg == ST_IDLE);
    assign rsp_valid = (state_reg == ST_DONE);
    assign rsp       = '{data: rdata_reg, ok: ok_reg, tries: tries_reg};
    assign pins      = pins_reg;

    always_comb begin
        state_next = state_reg;
        timer_next = timer_done ? T_ZERO : timer_reg - 1'b1;
        tries_next = tries_reg;
        ok_next    = ok_reg;
        sig_next   = sig_reg;
        want_next  = want_reg;
        rdata_next = rdata_reg;
        pins_next  = pins_reg;
        unique case (state_reg)
            ST_IDLE: begin
                pins_next = PINS_IDLE;
                if (cmd_valid) begin
                    tries_next = '0;
                    ok_next    = 1'b1;
                    want_next  = cmd.data;
                    pins_next.address_inputs = cmd.addr;
                    if (cmd.op == epm_pkg::EPM_OP_PROG) begin
                        sig_next                = 1'b0;
                        pins_next.vpp_high      = 1'b1;
                        pins_next.data_pins_out = cmd.data;
                        pins_next.data_pins_oe  = 1'b1;
                        timer_next              = T_SETUP;
                        state_next              = ST_SETUP;
                    end else begin
                        sig_next             = (cmd.op == epm_pkg::EPM_OP_SIG);
                        pins_next.chip_sel_n = 1'b0;
                        pins_next.out_drv_n  = 1'b0;
                        if (cmd.op == epm_pkg::EPM_OP_SIG) begin
                            pins_next.address_inputs = epm_pkg::ADDR_ZERO;
                            pins_next.address_inputs[epm_pkg::ID_BIT] =
                                cmd.addr[epm_pkg::ID_BIT];
                            pins_next.id_select_hv_pin = 1'b1;
                        end
                        timer_next = T_SAMPLE;
                        state_next = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (timer_done) begin
                    rdata_next = sig_reg ? (sync2_reg & epm_pkg::ID_MASK) : sync2_reg;
                    pins_next  = PINS_IDLE;
                    state_next = ST_DONE;
                end
            end
            ST_SETUP: begin
                if (timer_done) begin
                    pins_next.chip_sel_n = 1'b0;
                    tries_next           = tries_reg + TRY_ONE;
                    timer_next           = T_PULSE;
                    state_next           = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (timer_done) begin
                    pins_next.chip_sel_n = 1'b1;
                    timer_next           = T_DISABLE;
                    state_next           = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Data is held past the pulse end, then the bus is turned around
                pins_next.data_pins_oe = 1'b0;
                if (timer_done && !pins_reg.data_pins_oe) begin
                    pins_next.out_drv_n = 1'b0;
                    timer_next          = T_SAMPLE;
                    state_next          = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                if (timer_done) begin
                    pins_next.out_drv_n = 1'b1;
                    if (sync2_reg == want_reg) begin
                        timer_next = T_SETUP;
                        state_next = ST_REVERT;
                    end else if (unfixable != epm_pkg::DATA_ZERO ||
                                 tries_reg == TRY_MAX) begin
                        ok_next    = 1'b0;
                        timer_next = T_SETUP;
                        state_next = ST_REVERT;
                    end else begin
                        timer_next = T_DISABLE;
                        state_next = ST_TURN;
                    end
                    if (state_next == ST_REVERT) begin
                        pins_next.vpp_high = 1'b0;
                    end
                end
            end
            ST_TURN: begin
                if (timer_done) begin
                    pins_next.data_pins_out = want_reg;
                    pins_next.data_pins_oe  = 1'b1;
                    timer_next              = T_SETUP;
                    state_next              = ST_SETUP;
                end
            end
            ST_REVERT: begin
                if (timer_done) begin
                    pins_next.chip_sel_n = 1'b0;
                    pins_next.out_drv_n  = 1'b0;
                    timer_next           = T_SAMPLE;
                    state_next           = ST_FINAL;
                end
            end
            ST_FINAL: begin
                if (timer_done) begin
                    rdata_next = sync2_reg;
                    ok_next    = ok_reg && (sync2_reg == want_reg);
                    pins_next  = PINS_IDLE;
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            timer_reg <= '0;
            tries_reg <= '0;
            ok_reg    <= 1'b0;
            sig_reg   <= 1'b0;
            want_reg  <= '0;
            rdata_reg <= '0;
            pins_reg  <= '{address_inputs:   epm_pkg::ADDR_ZERO,
                           chip_sel_n:       1'b1,
                           out_drv_n:        1'b1,
                           vpp_high:         1'b0,
                           id_select_hv_pin: 1'b0,
                           data_pins_out:    epm_pkg::DATA_ZERO,
                           data_pins_oe:     1'b0};
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            tries_reg <= tries_next;
            ok_reg    <= ok_next;
            sig_reg   <= sig_next;
            want_reg  <= want_next;
            rdata_reg <= rdata_next;
            pins_reg  <= pins_next;
            sync1_reg <= data_pins_in;
            sync2_reg <= sync1_reg;
        end
    end

endmodule

// ---- tb/epm_host_checker.sv ----
`timescale 1ns/1ps
module epm_host_checker #(
    parameter int PULSE_CYCLES = epm_pkg::PULSE_NOM_CYC
) (
    input wire logic                       clk,
    input wire logic                       nrst,
    input wire logic                       cmd_valid,
    input wire logic                       cmd_ready,
    input wire epm_pkg::epm_cmd_t          cmd,
    input wire logic                       rsp_valid,
    input wire epm_pkg::epm_rsp_t          rsp,
    input wire epm_pkg::epm_pins_t         pins,
    input wire logic [epm_pkg::DATA_W-1:0] data_pins_in
);
    logic [15:0]      low_reg, low_next;
    epm_pkg::epm_op_t op_reg, op_next;
    always_comb begin
        low_next = (!pins.chip_sel_n && pins.vpp_high) ? low_reg + 16'h0001 : 16'h0000;
        op_next  = (cmd_valid && cmd_ready) ? cmd.op : op_reg;
    end
    always_ff @(posedge clk) begin
        low_reg <= nrst ? low_next : 16'h0000;
        op_reg  <= nrst ? op_next : epm_pkg::EPM_OP_READ;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_take_rd;
        cmd_valid && cmd_ready && cmd.op == epm_pkg::EPM_OP_READ;
    endsequence
    sequence s_read_hold;
        (!pins.chip_sel_n && !pins.out_drv_n && !pins.vpp_high)[*8];
    endsequence
    a_read_then_rsp: assert property (s_take_rd |=> s_read_hold ##[8:12] rsp_valid)
        else $error("read cycle malformed");
    a_read_addr: assert property (s_take_rd |=> pins.address_inputs == $past(cmd.addr))
        else $error("read address not presented");
    a_no_contend: assert property (pins.data_pins_oe |-> pins.out_drv_n)
        else $error("data pins driven while output drive is on");
    a_pulse_len: assert property ($rose(pins.chip_sel_n) && pins.vpp_high |-> int'(low_reg) == PULSE_CYCLES)
        else $error("program pulse length wrong");
    a_prog_setup: assert property ($fell(pins.chip_sel_n) && pins.vpp_high |-> $past(pins.vpp_high) && pins.out_drv_n && pins.data_pins_oe && $stable(pins.address_inputs))
        else $error("program pulse without setup");
    a_verify_mode: assert property (pins.vpp_high && !pins.out_drv_n |-> pins.chip_sel_n && !pins.data_pins_oe)
        else $error("verify with wrong enables");
    a_sig_addr: assert property (pins.id_select_hv_pin |-> pins.address_inputs[17:1] == 17'h00000 && !pins.vpp_high)
        else $error("id read with stray address bits");
    a_try_limit: assert property (rsp_valid |-> rsp.tries <= 4'ha && (op_reg != epm_pkg::EPM_OP_PROG || rsp.tries != 4'h0))
        else $error("pulse count out of range");
    a_sig_byte: assert property (rsp_valid && op_reg == epm_pkg::EPM_OP_SIG |-> rsp.data[15:8] == 8'h00)
        else $error("id upper byte not cleared");
endmodule
bind epm_host epm_host_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_checker (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_pins_in(data_pins_in));

// ---- tb/epm_dev_model.sv ----
`timescale 1ns/1ps
module epm_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [7:0] PART_ID  = 8'hc3
) (
    input wire logic               clk,
    input wire epm_pkg::epm_pins_t pins,
    input wire logic [31:0]        need,
    output logic [15:0]            level
);
    logic [15:0] mem [0:262143];
    int          hits [0:262143];
    logic [15:0] last = 16'h0000;
    logic [15:0] word, pd;
    logic [17:0] pa;
    logic        drive, rd, vfy;
    logic        low_seen = 1'b0;
    initial begin
        for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
    end
    always_comb begin
        rd    = !pins.chip_sel_n && !pins.out_drv_n && !pins.vpp_high;
        vfy   = pins.chip_sel_n && !pins.out_drv_n && pins.vpp_high;
        word  = mem[pins.address_inputs];
        if (rd && pins.id_select_hv_pin) begin
            word = {8'ha5, pins.address_inputs[0] ? PART_ID : MAKER_ID};
        end
        drive = rd || vfy;
        level = pins.data_pins_oe ? pins.data_pins_out : (drive ? word : ~last);
    end
    // Floating pins show the inverse of the last driven value
    always @(posedge clk) begin
        if (drive || pins.data_pins_oe) last <= level;
        if (pins.vpp_high && pins.out_drv_n && !pins.chip_sel_n) begin
            low_seen <= 1'b1;
            pa <= pins.address_inputs;
            pd <= pins.data_pins_out;
        end else if (low_seen && pins.chip_sel_n) begin
            low_seen <= 1'b0;
            hits[pa] = hits[pa] + 1;
            if (hits[pa] >= int'(need)) mem[pa] <= mem[pa] & pd;
        end
    end
endmodule

// ---- tb/eprom_mode_decode_and_program_test.sv ----
`timescale 1ns/1ps
module eprom_mode_decode_and_program_test;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
    localparam logic [7:0] PART  = 8'hc3; // Arbitrary value
    logic               clk       = 1'b0;
    logic               nrst      = 1'b0;
    logic               cmd_valid = 1'b0;
    logic               cmd_ready, rsp_valid;
    epm_pkg::epm_cmd_t  cmd       = '0;
    epm_pkg::epm_rsp_t  rsp, got;
    epm_pkg::epm_pins_t pins;
    logic [15:0]        level;
    int                 need      = 1;
    int                 n_fail    = 0;
    int                 cmp_count = 0;
    always #5 clk = ~clk;
    epm_host #(.PULSE_CYCLES(20)) dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
        .data_pins_in(level));
    epm_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dev (.clk(clk), .pins(pins),
        .need(need), .level(level));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run_cmd(input epm_pkg::epm_op_t op, input logic [17:0] addr,
                           input logic [15:0] data);
        int i;
        int j;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, addr: addr, data: data};
        for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (j = 0; j < 40000 && rsp_valid !== 1'b1; j++) @(negedge clk);
        if (i == 50 || j == 40000) begin
            n_fail++;
            print_verdict();
        end
        got = rsp;
    endtask
    task automatic t_prog(input logic [17:0] a, input logic [15:0] d, input int n,
                          input logic ok, input logic [3:0] tries, input logic [15:0] fin);
        need = n;
        run_cmd(epm_pkg::EPM_OP_PROG, a, d);
        check("prog ok", {15'h0000, ok}, {15'h0000, got.ok});
        check("prog tries", {12'h000, tries}, {12'h000, got.tries});
        check("final read", fin, got.data);
    endtask
    task automatic t_blank();
        check("idle enables", 16'h000c, {12'h000, pins.chip_sel_n, pins.out_drv_n,
            pins.vpp_high, pins.data_pins_oe});
        run_cmd(epm_pkg::EPM_OP_READ, 18'h3ffff, 16'h0000);
        check("blank word", 16'hffff, got.data);
    endtask
    task automatic t_addr_bits();
        logic [17:0] adr [3] = '{18'h00201, 18'h00200, 18'h00001};
        logic [15:0] exp [3] = '{16'h1234, 16'hffff, 16'hffff};
        for (int k = 0; k < 3; k++) begin
            run_cmd(epm_pkg::EPM_OP_READ, adr[k], 16'h0000);
            check("read word", exp[k], got.data);
        end
    endtask
    task automatic t_sig();
        for (int b = 0; b < 2; b++) begin
            run_cmd(epm_pkg::EPM_OP_SIG, {17'h1ffff, b[0]}, 16'h0000);
            check("id byte", {8'h00, b[0] ? PART : MAKER}, got.data);
        end
        run_cmd(epm_pkg::EPM_OP_READ, 18'h00000, 16'h0000);
        check("plain read after id", 16'hffff, got.data);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_blank();
        t_prog(18'h00201, 16'h1234, 1, 1'b1, 4'h1, 16'h1234);
        t_addr_bits();
        t_prog(18'h00300, 16'h00f0, 3, 1'b1, 4'h3, 16'h00f0);
        t_prog(18'h00400, 16'h0000, 20, 1'b0, 4'ha, 16'hffff);
        t_prog(18'h00201, 16'hffff, 1, 1'b0, 4'h1, 16'h1234);
        t_sig();
        print_verdict();
    end
endmodule
